// ==== test/tkad_front_model.sv ====
// Front end model: answers each burst with one count per key.
// Assumes the sequencer raises a one-cycle start and then waits for done.
`default_nettype none
module tkad_front_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [7:0] i_keys,
  input wire logic [7:0] i_touch,
  output logic o_done,
  output logic [127:0] o_counts
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cyc = -1;
  initial {o_done, o_counts} = '0;
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_counts <= ~o_counts; // Counts churn outside done so a stale value is never mistaken for a fresh one.
    if (i_start) begin
      wait_cyc <= ((i_keys & i_touch) != 8'h00) ? 6 : 3;
    end else if (wait_cyc > 0) begin
      wait_cyc <= wait_cyc - 1;
    end else if (wait_cyc == 0) begin
      wait_cyc <= -1;
      o_done <= 1'b1;
      for (int k = 0; k < 8; k++) begin
        o_counts[k*16+:16] <= i_touch[k] ? 16'h0380 : 16'h0400;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/tkad_properties.sv ====
// Checker for the touch key top: burst order, group masks and key outputs.
// Assumes it is bound to tkad_top and sees its ports only.
`default_nettype none
module tkad_properties import tkad_pkg::*; #(
  parameter int NKEYS = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire tkad_pkg::tkad_cfg_t i_cfg,
  input wire logic i_burst_done,
  input wire logic o_burst_start,
  input wire logic o_burst_group_b,
  input wire logic [NKEYS-1:0] o_burst_keys,
  input wire logic [3:0] o_spread_step,
  input wire logic o_sleeping,
  input wire logic o_cal_busy,
  input wire logic [NKEYS-1:0] o_key,
  input wire logic o_detect
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_group_a_mask: assert property (o_burst_start && !o_burst_group_b |-> o_burst_keys == 8'h33)
    else $error("group A mask wrong");
  a_group_b_mask: assert property (o_burst_start && o_burst_group_b |-> o_burst_keys == 8'hCC)
    else $error("group B mask wrong");
  a_group_toggle: assert property (i_burst_done |=> o_burst_group_b != $past(o_burst_group_b))
    else $error("group did not alternate");
  a_start_gap: assert property (i_burst_done && !i_cfg.sleep_between_bursts_mode |-> ##2 o_burst_start)
    else $error("next burst late");
  a_cal_quiet: assert property (o_cal_busy |-> o_key == 8'h00)
    else $error("key set during calibration");
  a_sleep_quiet: assert property (o_sleeping |-> !o_burst_start)
    else $error("burst while sleeping");
  a_key_cause: assert property ((o_key & ~$past(o_key)) != 8'h00 |-> $past(i_burst_done, 2))
    else $error("key set without burst");
  a_detect_any: assert property ($rose(|o_key) |-> ##[0:1] o_detect)
    else $error("detect not raised");
  a_spread_hop: assert property (o_burst_start |-> o_spread_step != $past(o_spread_step))
    else $error("spread step repeated");
  c_key_touch: cover property ($rose(o_key[0]));
  c_burst_b: cover property (o_burst_start && o_burst_group_b);
  c_sleep: cover property ($rose(o_sleeping));
endmodule
bind tkad_top tkad_properties #(.NKEYS(NKEYS)) u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cfg(i_cfg),
  .i_burst_done(i_burst_done), .o_burst_start(o_burst_start), .o_burst_group_b(o_burst_group_b),
  .o_burst_keys(o_burst_keys), .o_spread_step(o_spread_step), .o_sleeping(o_sleeping), .o_cal_busy(o_cal_busy),
  .o_key(o_key), .o_detect(o_detect));
`default_nettype wire

// ==== test/touch_key_acquire_debounce_tb_top.sv ====
// Bench for the touch key top: drives touches and options, checks key outputs.
// Assumes tkad_front_model answers the bursts.
`default_nettype none
module touch_key_acquire_debounce_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tkad_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  tkad_cfg_t cfg = '0;
  logic lp_req = 1'b0;
  logic [7:0] touch = 8'h00;
  logic done, start, grp_b, sleeping, cal_busy, detect;
  logic [127:0] counts;
  logic [7:0] keys, key_out;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  tkad_top #(.CAL_CYC(100), .MS_CYC(1)) dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_cfg(cfg), .i_lp_request(lp_req),
    .i_burst_done(done), .i_counts(counts), .o_burst_start(start), .o_burst_group_b(grp_b), .o_burst_keys(keys),
    .o_spread_step(), .o_sleeping(sleeping), .o_cal_busy(cal_busy), .o_key(key_out), .o_detect(detect));
  tkad_front_model fe (.i_clk(clk), .i_start(start), .i_keys(keys), .i_touch(touch), .o_done(done), .o_counts(counts));
  task automatic complete_run();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts n finished bursts of group g, lets the two-cycle answer land, then checks the keys.
  task automatic bursts(input int n, input logic g, input logic [7:0] exp);
    int seen;
    seen = 0;
    while (seen < n) begin
      @(posedge clk);
      if (done === 1'b1 && grp_b === g) seen++;
    end
    repeat (3) @(posedge clk);
    check(key_out, exp);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    check(key_out, 8'h00);
    check({7'h00, cal_busy}, 8'h01);
    rst_b <= 1'b1;
    while (cal_busy !== 1'b0) @(posedge clk);
    bursts(1, 1'b0, 8'h00);
    touch <= 8'h01;
    bursts(5, 1'b0, 8'h00);
    bursts(1, 1'b0, 8'h01);
    check({7'h00, detect}, 8'h01);
    touch <= 8'h00;
    bursts(5, 1'b0, 8'h01);
    bursts(1, 1'b0, 8'h00);
    touch <= 8'h01;
    bursts(4, 1'b0, 8'h00);
    touch <= 8'h00;
    bursts(1, 1'b0, 8'h00);
    touch <= 8'h01;
    bursts(5, 1'b0, 8'h00);
    bursts(1, 1'b0, 8'h01);
    touch <= 8'h00;
    bursts(6, 1'b0, 8'h00);
    cfg.recal_sel <= TKAD_RECAL_10S;
    touch <= 8'h01;
    bursts(6, 1'b0, 8'h01);
    repeat (9900) @(posedge clk);
    check(key_out, 8'h01);
    repeat (200) @(posedge clk);
    check(key_out, 8'h00);
    cfg.recal_sel <= TKAD_RECAL_OFF;
    touch <= 8'h00;
    repeat (2100) @(posedge clk);
    touch <= 8'h01;
    bursts(5, 1'b0, 8'h00);
    bursts(1, 1'b0, 8'h01);
    touch <= 8'h00;
    bursts(6, 1'b0, 8'h00);
    cfg.fast_detect <= 1'b1;
    touch <= 8'h01;
    bursts(1, 1'b0, 8'h00);
    bursts(1, 1'b0, 8'h01);
    touch <= 8'h00;
    bursts(5, 1'b0, 8'h01);
    bursts(1, 1'b0, 8'h00);
    cfg.neighbour_suppress <= 1'b1;
    touch <= 8'h01;
    bursts(2, 1'b0, 8'h00);
    bursts(4, 1'b0, 8'h01);
    touch <= 8'h80;
    bursts(5, 1'b1, 8'h01);
    bursts(1, 1'b1, 8'h81);
    touch <= 8'h00;
    bursts(6, 1'b1, 8'h00);
    cfg <= '{1'b1, 1'b0, 1'b0, TKAD_RECAL_OFF};
    lp_req <= 1'b1;
    @(posedge clk);
    lp_req <= 1'b0;
    for (int i = 0; i < 600 && sleeping !== 1'b1; i++) @(posedge clk);
    check({7'h00, sleeping}, 8'h01);
    touch <= 8'h02;
    bursts(6, 1'b0, 8'h02);
    repeat (300) @(posedge clk);
    check({6'h00, sleeping, detect}, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire

// ==== verilog/tkad_key.sv ====
// One key's reference tracking, recalibration and confirmation counter.
// Assumes a measurement strobe and millisecond tick from the top module.
`default_nettype none
`include "tkad_map.svh"
module tkad_key #(
  parameter int CNT_W = `TKAD_CNT_W,
  parameter int MS_PER_S = 1000
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_meas,
  input wire logic [CNT_W-1:0] i_count,
  input wire logic i_cal,
  input wire logic i_ms_tick,
  input wire logic [3:0] i_touch_lim,
  input wire logic [1:0] i_recal_sel,
  output logic o_touched
);
  import tkad_pkg::*;
  logic [CNT_W-1:0] ref_r;
  logic [CNT_W-1:0] last_r;
  logic [3:0] touch_confirm_counter_r;
  logic [15:0] up_ms_r, dn_ms_r, neg_ms_r;
  logic [16:0] hold_ms_r;
  logic detect, negative, recal;
  logic [16:0] hold_lim;
  logic [3:0] lim;

  // Touch pulls the count below the reference, as load capacitance rises.
  assign detect = (ref_r > i_count) && ((ref_r - i_count) > `TKAD_DETECT_THR);
  assign negative = (last_r > ref_r) && ((last_r - ref_r) > `TKAD_NEG_THR);
  assign hold_lim = (i_recal_sel == 2'(TKAD_RECAL_10S)) ? 17'(`TKAD_RECAL_SHORT_S * MS_PER_S) :
                    17'(`TKAD_RECAL_LONG_S * MS_PER_S);
  assign recal = i_cal
    || (o_touched && i_recal_sel != 2'(TKAD_RECAL_OFF) && hold_ms_r >= hold_lim)
    || (neg_ms_r >= 16'(`TKAD_NEG_RECAL_MS));
  // Release always needs the normal count; only touch start may be fast.
  assign lim = o_touched ? `TKAD_DI_NORMAL : i_touch_lim;

  // Counts are only valid with a strobe, so drift and timed recalibration use the last one taken.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) last_r <= '0;
    else if (i_meas || i_cal) last_r <= i_count;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ref_r <= '0;
      up_ms_r <= '0;
      dn_ms_r <= '0;
    end else if (recal) begin
      ref_r <= i_cal ? i_count : last_r;
      up_ms_r <= '0;
      dn_ms_r <= '0;
    end else begin
      if (i_ms_tick && !o_touched) begin
        up_ms_r <= (ref_r > last_r) ? up_ms_r + 16'h0001 : 16'h0000;
        dn_ms_r <= (last_r > ref_r) ? dn_ms_r + 16'h0001 : 16'h0000;
      end
      if (up_ms_r >= 16'(`TKAD_DRIFT_UP_MS)) begin
        ref_r <= ref_r - 1'b1;
        up_ms_r <= '0;
      end else if (dn_ms_r >= 16'(`TKAD_DRIFT_DN_MS)) begin
        ref_r <= ref_r + 1'b1;
        dn_ms_r <= '0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_ms_r <= '0;
      neg_ms_r <= '0;
    end else if (recal) begin
      hold_ms_r <= '0;
      neg_ms_r <= '0;
    end else if (i_ms_tick) begin
      hold_ms_r <= o_touched ? hold_ms_r + 17'h00001 : 17'h00000;
      neg_ms_r <= negative ? neg_ms_r + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      touch_confirm_counter_r <= '0;
      o_touched <= 1'b0;
    end else if (recal) begin
      touch_confirm_counter_r <= '0;
      o_touched <= 1'b0;
    end else if (i_meas) begin
      if (detect != o_touched) begin
        if (touch_confirm_counter_r + 4'h1 >= lim) begin
          o_touched <= detect;
          touch_confirm_counter_r <= '0;
        end else begin
          touch_confirm_counter_r <= touch_confirm_counter_r + 4'h1;
        end
      end else begin
        touch_confirm_counter_r <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/tkad_map.svh ====
// Constants for the touch key acquire and debounce block.
// Assumes a 50 MHz core clock; included by the package and the design files.
`ifndef TKAD_MAP_SVH
`define TKAD_MAP_SVH
`define TKAD_CLK_HZ 50000000
`define TKAD_NKEYS 8
`define TKAD_CNT_W 16
`define TKAD_GROUP_A_MASK 8'h33
`define TKAD_GROUP_B_MASK 8'hCC
`define TKAD_CAL_MS 300
`define TKAD_CAL_CYC ((`TKAD_CAL_MS * (`TKAD_CLK_HZ / 1000)))
`define TKAD_DRIFT_UP_MS 2000
`define TKAD_DRIFT_DN_MS 500
`define TKAD_NEG_RECAL_MS 2000
`define TKAD_RECAL_SHORT_S 10
`define TKAD_RECAL_LONG_S 60
`define TKAD_MS_CYC (`TKAD_CLK_HZ / 1000)
`define TKAD_DI_NORMAL 4'h6
`define TKAD_DI_FAST 4'h2
`define TKAD_DETECT_THR 16'h0010
`define TKAD_NEG_THR 16'h0008
`define TKAD_SLEEP_CYC 16'h00FF
`endif

// ==== verilog/tkad_pkg.sv ====
// Types shared by the touch key block.
// Assumes tkad_map.svh is on the include path.
`default_nettype none
`include "tkad_map.svh"
package tkad_pkg;
  typedef enum logic [1:0] {
    TKAD_RECAL_OFF,
    TKAD_RECAL_10S,
    TKAD_RECAL_60S
  } tkad_recal_t;
  typedef struct packed {
    logic sleep_between_bursts_mode;
    logic fast_detect;
    logic neighbour_suppress;
    tkad_recal_t recal_sel;
  } tkad_cfg_t;
  typedef struct packed {
    logic valid;
    logic group_b;
    logic [`TKAD_NKEYS*`TKAD_CNT_W-1:0] counts;
  } tkad_meas_t;
endpackage
`default_nettype wire

// ==== verilog/tkad_top.sv ====
// Sequencer for the eight-key touch sensor: bursts, calibration and outputs.
// Assumes the analog front end returns one count per key per burst.
`default_nettype none
`include "tkad_map.svh"
module tkad_top #(
  parameter int NKEYS = `TKAD_NKEYS,
  parameter int CNT_W = `TKAD_CNT_W,
  parameter int CAL_CYC = `TKAD_CAL_CYC,
  parameter int MS_CYC = `TKAD_MS_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire tkad_pkg::tkad_cfg_t i_cfg,
  input wire logic i_lp_request,
  input wire logic i_burst_done,
  input wire logic [NKEYS*CNT_W-1:0] i_counts,
  output logic o_burst_start,
  output logic o_burst_group_b,
  output logic [NKEYS-1:0] o_burst_keys,
  output logic [3:0] o_spread_step,
  output logic o_sleeping,
  output logic o_cal_busy,
  output logic [NKEYS-1:0] o_key,
  output logic o_detect
);
  import tkad_pkg::*;
  typedef enum logic [2:0] {TKAD_ST_START, TKAD_ST_WAIT, TKAD_ST_SLEEP} tkad_st_t;
  tkad_st_t st_r;
  logic rst_s1_r, rst_s2_r;
  logic [31:0] cal_r;
  logic [31:0] ms_r;
  logic ms_tick;
  logic lp_r;
  logic [15:0] sleep_r;
  logic [3:0] lfsr_r;
  logic [NKEYS-1:0] touched;
  logic [3:0] touch_lim;
  logic cal_now;
  logic cal_a_r;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign ms_tick = (ms_r == 32'(MS_CYC - 1));
  always_ff @(posedge i_core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) ms_r <= '0;
    else ms_r <= ms_tick ? 32'h0 : ms_r + 32'h1;
  end

  // Calibration takes the readings after the settle window as references; group B takes its second one if the window closes on B.
  always_ff @(posedge i_core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      cal_r <= '0;
      cal_a_r <= 1'b0;
      o_cal_busy <= 1'b1;
    end else if (o_cal_busy) begin
      // A window that closes on group B waits for the next pair, so both groups hold references.
      if (cal_r < 32'(CAL_CYC)) cal_r <= cal_r + 32'h1;
      else if (i_burst_done && !o_burst_group_b) cal_a_r <= 1'b1;
      else if (i_burst_done && cal_a_r) o_cal_busy <= 1'b0;
    end
  end
  assign cal_now = o_cal_busy && (cal_r >= 32'(CAL_CYC)) && i_burst_done;

  // Fast detect could let a suppressed key through, so it yields to suppression.
  assign touch_lim = (i_cfg.fast_detect && !i_cfg.neighbour_suppress) ? `TKAD_DI_FAST : `TKAD_DI_NORMAL;

  // Low power holds until a touch; the host must request it again afterwards.
  always_ff @(posedge i_core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) lp_r <= 1'b0;
    else if (|touched) lp_r <= 1'b0;
    else if (i_lp_request && i_cfg.sleep_between_bursts_mode) lp_r <= 1'b1;
  end

  always_ff @(posedge i_core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) lfsr_r <= 4'h1;
    else if (o_burst_start) lfsr_r <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
  end

  always_ff @(posedge i_core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      st_r <= TKAD_ST_START;
      o_burst_start <= 1'b0;
      o_burst_group_b <= 1'b0;
      o_burst_keys <= '0;
      o_spread_step <= '0;
      o_sleeping <= 1'b0;
      sleep_r <= '0;
    end else begin
      o_burst_start <= 1'b0;
      case (st_r)
        TKAD_ST_START: begin
          o_burst_start <= 1'b1;
          o_spread_step <= lfsr_r;
          o_burst_keys <= o_burst_group_b ? `TKAD_GROUP_B_MASK : `TKAD_GROUP_A_MASK;
          st_r <= TKAD_ST_WAIT;
        end
        TKAD_ST_WAIT: begin
          // The front end ends the burst when its pulse count is reached.
          if (i_burst_done) begin
            o_burst_group_b <= ~o_burst_group_b;
            if (lp_r) begin
              st_r <= TKAD_ST_SLEEP;
              o_sleeping <= 1'b1;
              sleep_r <= `TKAD_SLEEP_CYC;
            end else begin
              st_r <= TKAD_ST_START;
            end
          end
        end
        TKAD_ST_SLEEP: begin
          if (sleep_r == 16'h0000 || !lp_r) begin
            o_sleeping <= 1'b0;
            st_r <= TKAD_ST_START;
          end else begin
            sleep_r <= sleep_r - 16'h0001;
          end
        end
        default: st_r <= TKAD_ST_START;
      endcase
    end
  end

  genvar k;
  generate
    for (k = 0; k < NKEYS; k++) begin : g_key
      localparam logic IN_B = ((`TKAD_GROUP_B_MASK >> k) & 1) != 0;
      tkad_key #(.CNT_W(CNT_W)) u_key (
        .i_clk(i_core_clk),
        .i_rst_b(rst_s2_r),
        .i_meas(i_burst_done && st_r == TKAD_ST_WAIT && (o_burst_group_b == IN_B) && !o_cal_busy),
        .i_count(i_counts[k*CNT_W +: CNT_W]),
        .i_cal(cal_now && (o_burst_group_b == IN_B)),
        .i_ms_tick(ms_tick),
        .i_touch_lim(touch_lim),
        .i_recal_sel(i_cfg.recal_sel),
        .o_touched(touched[k])
      );
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      o_key <= '0;
      o_detect <= 1'b0;
    end else begin
      o_key <= touched;
      o_detect <= |touched;
    end
  end
endmodule
`default_nettype wire
